// File: src/column_mem_pkg.sv
// Purpose: Shared constants for the steering column memory controller
// Assumes: 10 MHz pclk, APB register access with 32-bit words
// Notes: Time figures in milliseconds; cycle counts derived from the clock
package column_mem_pkg;
   // Clock rate and cycles per millisecond
   localparam int CLK_HZ = 10_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   // Register byte offsets
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] POS_OFS = 8'h08;
   localparam logic [7:0] SLOT0_OFS = 8'h0c;
   localparam logic [7:0] SLOT1_OFS = 8'h10;
   // Command register bit positions (write-only pulses)
   localparam int CMD_PERMIT = 0;
   localparam int CMD_REG0 = 1;
   localparam int CMD_REG1 = 2;
   localparam int CMD_PLAY0 = 3;
   localparam int CMD_PLAY1 = 4;
   localparam int CMD_LOCK = 5;
   localparam int CMD_UNLOCK = 6;
   localparam int CMD_KEYSLOT = 7;
   // Status register bit positions
   localparam int ST_PERMIT = 0;
   localparam int ST_VALID0 = 1;
   localparam int ST_VALID1 = 2;
   localparam int ST_PLAY = 3;
   localparam int ST_FAULT = 4;
   localparam int ST_BUZZ = 5;
   localparam int ST_PEND = 6;
   // Position counter width
   localparam int POS_W = 16;
   // Times as specified
   localparam int GAP_MS = 50;
   localparam int STAGGER_MS = 100;
   localparam int WIN_MS = 1000;
   localparam int SPEED_MS = 2500;
   localparam int BEEP_MS = 150;
   // Derived cycle counts
   localparam int GAP_CYC = GAP_MS * CYC_PER_MS;
   localparam int STAGGER_CYC = STAGGER_MS * CYC_PER_MS;
   localparam int WIN_CYC = WIN_MS * CYC_PER_MS;
   localparam int SPEED_CYC = SPEED_MS * CYC_PER_MS;
   localparam int BEEP_CYC = BEEP_MS * CYC_PER_MS;
   // Sensor pulse threshold and beep counts
   localparam logic [2:0] PULSE_MIN = 3'h4;
   localparam logic [3:0] BEEPS_PERMIT = 4'h1;
   localparam logic [3:0] BEEPS_REG = 4'h2;
   localparam logic [3:0] BEEPS_PLAY = 4'h1;
   localparam logic [3:0] BEEPS_FAULT = 4'ha;
   // Replay sequencer states, Gray along the path
   typedef enum logic [1:0] {
      P_IDLE = 2'h0,
      P_TILT = 2'h1,
      P_TELE = 2'h3
   } play_e;
endpackage

// File: src/column_mem_ctrl.sv
// Purpose: Tilt/telescope column drive with two memory slots and replay
// Assumes: Door module commands arrive as APB writes; pins are async
// Notes: Axis 0 is tilt (pos=up), axis 1 is telescope (pos=forward)
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module column_mem_ctrl #(
   parameter int GAP_CYC = column_mem_pkg::GAP_CYC,
   parameter int STAGGER_CYC = column_mem_pkg::STAGGER_CYC,
   parameter int WIN_CYC = column_mem_pkg::WIN_CYC,
   parameter int SPEED_CYC = column_mem_pkg::SPEED_CYC,
   parameter int BEEP_CYC = column_mem_pkg::BEEP_CYC,
   parameter int CNT_W = 25
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Vehicle state pins
   input wire logic ign_on,
   input wire logic park_on,
   input wire logic speed_high,
   input wire logic stop_sw,
   // Column switches and sensors, index 0 tilt, 1 telescope
   input wire logic [1:0] man_pos_sw,
   input wire logic [1:0] man_neg_sw,
   input wire logic [1:0] limit_ok,
   input wire logic [1:0] sens_pulse,
   // Motor and buzzer drive
   output logic [1:0] mot_pos,
   output logic [1:0] mot_neg,
   output logic buzzer
);
   localparam int PW = column_mem_pkg::POS_W;
   localparam logic [CNT_W-1:0] GAP_END = CNT_W'(GAP_CYC - 1);
   localparam logic [CNT_W-1:0] STG_END = CNT_W'(STAGGER_CYC - 1);
   localparam logic [CNT_W-1:0] WIN_END = CNT_W'(WIN_CYC - 1);
   localparam logic [CNT_W-1:0] SPD_END = CNT_W'(SPEED_CYC);
   localparam logic [CNT_W-1:0] BEEP_END = CNT_W'(BEEP_CYC - 1);

   // Counters must hold every count; refuse settings that overflow
   if (CNT_W < 2 || CNT_W > 31 || GAP_CYC < 1 || STAGGER_CYC < 1 ||
       WIN_CYC < 1 || BEEP_CYC < 1 || SPEED_CYC < 1 ||
       GAP_CYC >= (1 << CNT_W) || STAGGER_CYC >= (1 << CNT_W) ||
       WIN_CYC >= (1 << CNT_W) || SPEED_CYC >= (1 << CNT_W) ||
       BEEP_CYC >= (1 << CNT_W)) begin : bad_params
      $error("column_mem_ctrl: timer count does not fit CNT_W");
   end

   // Address decode, shared by write enable and error answer
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == column_mem_pkg::CMD_OFS) ||
                (a == column_mem_pkg::STAT_OFS) ||
                (a == column_mem_pkg::POS_OFS) ||
                (a == column_mem_pkg::SLOT0_OFS) ||
                (a == column_mem_pkg::SLOT1_OFS);
   endfunction

   // Synchroniser for all pin inputs; stage one feeds stage two only
   logic [11:0] sync1_ff;
   logic [11:0] sync2_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 12'h000;
         sync2_ff <= 12'h000;
      end else begin
         sync1_ff <= {ign_on, park_on, speed_high, stop_sw, man_pos_sw,
                      man_neg_sw, limit_ok, sens_pulse};
         sync2_ff <= sync1_ff;
      end
   end
   logic ign_s, park_s, speed_s, stop_s;
   logic [1:0] sw_pos, sw_neg, lim, pulse_s;
   assign {ign_s, park_s, speed_s, stop_s, sw_pos, sw_neg, lim,
           pulse_s} = sync2_ff;

   // Pulse edge detect on the synchronised sensor lines
   logic [1:0] pulse_d_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pulse_d_ff <= 2'h0;
      else pulse_d_ff <= pulse_s;
   end
   logic [1:0] pulse_rise;
   assign pulse_rise = pulse_s & ~pulse_d_ff;
   logic manual_any;
   assign manual_any = (|sw_pos) | (|sw_neg);

   // APB: zero wait states, error on unmapped offsets
   logic acc, wr_acc;
   assign acc = psel & penable;
   assign wr_acc = acc & pwrite & reg_hit(paddr);
   assign pready = 1'b1;
   assign pslverr = acc & ~reg_hit(paddr);

   // Command pulses from door module messages relayed by software
   logic cmd_wr;
   assign cmd_wr = wr_acc & (paddr == column_mem_pkg::CMD_OFS);
   logic cmd_permit, lock_ev, unlock_ev, key_slot;
   logic [1:0] reg_bits, play_bits;
   assign cmd_permit = cmd_wr & pwdata[column_mem_pkg::CMD_PERMIT];
   assign reg_bits = cmd_wr ? {pwdata[column_mem_pkg::CMD_REG1],
                               pwdata[column_mem_pkg::CMD_REG0]} : 2'h0;
   assign play_bits = cmd_wr ? {pwdata[column_mem_pkg::CMD_PLAY1],
                                pwdata[column_mem_pkg::CMD_PLAY0]} : 2'h0;
   assign lock_ev = cmd_wr & pwdata[column_mem_pkg::CMD_LOCK];
   assign unlock_ev = cmd_wr & pwdata[column_mem_pkg::CMD_UNLOCK];
   assign key_slot = pwdata[column_mem_pkg::CMD_KEYSLOT];
   // Both slots in one write count as a simultaneous press
   logic press, press_slot, press_play, both_pressed;
   assign both_pressed = (&reg_bits) | (&play_bits) |
                         ((|reg_bits) & (|play_bits) &
                          (reg_bits != play_bits));
   assign press = (|reg_bits | |play_bits) & ~both_pressed;
   assign press_slot = reg_bits[1] | play_bits[1];
   assign press_play = |play_bits;

   // Speed must persist before it aborts replay
   logic [CNT_W-1:0] spd_cnt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) spd_cnt_ff <= '0;
      else if (!speed_s) spd_cnt_ff <= '0;
      else if (spd_cnt_ff != SPD_END) spd_cnt_ff <= spd_cnt_ff + 1'b1;
   end
   logic speed_long, store_ok;
   assign speed_long = (spd_cnt_ff == SPD_END);
   assign store_ok = park_s & ~speed_s;

   // Memory permit status
   logic permit_ff, permit_rise;
   assign permit_rise = cmd_permit & ~permit_ff & ign_s & ~manual_any;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) permit_ff <= 1'b0;
      else if (!ign_s || manual_any) permit_ff <= 1'b0;
      else if (cmd_permit) permit_ff <= 1'b1;
   end

   // Press arbitration: a press commits only after the gap passes,
   // so a second press inside the gap can still cancel it
   logic pend_ff, pend_slot_ff, pend_play_ff;
   logic [CNT_W-1:0] gap_cnt_ff;
   logic commit;
   assign commit = pend_ff & ~press & ~both_pressed &
                   (gap_cnt_ff == GAP_END);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= 1'b0;
         pend_slot_ff <= 1'b0;
         pend_play_ff <= 1'b0;
         gap_cnt_ff <= '0;
      end else if (both_pressed) begin
         pend_ff <= 1'b0;
      end else if (press) begin
         if (pend_ff && press_slot != pend_slot_ff) begin
            pend_ff <= 1'b0;
         end else begin
            pend_ff <= 1'b1;
            pend_slot_ff <= press_slot;
            pend_play_ff <= press_play;
            gap_cnt_ff <= '0;
         end
      end else if (pend_ff) begin
         if (commit) pend_ff <= 1'b0;
         else gap_cnt_ff <= gap_cnt_ff + 1'b1;
      end
   end
   logic commit_reg, commit_play;
   assign commit_reg = commit & ~pend_play_ff & permit_ff;
   assign commit_play = commit & pend_play_ff;

   // Position counters, one per axis
   logic [PW-1:0] pos_ff [2];
   logic [1:0] mot_pos_ff, mot_neg_ff;
   // Memory slots, index {slot, axis}
   logic [PW-1:0] slot_pos_ff [4];
   logic [1:0] valid_ff;
   logic store_en, store_slot;
   assign store_en = store_ok & (commit_reg | lock_ev);
   assign store_slot = lock_ev ? key_slot : pend_slot_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_ff <= 2'h0;
         for (int i = 0; i < 4; i++) slot_pos_ff[i] <= '0;
      end else if (store_en) begin
         // Overwrite always allowed, slots kept apart
         valid_ff[store_slot] <= 1'b1;
         slot_pos_ff[{store_slot, 1'b0}] <= pos_ff[0];
         slot_pos_ff[{store_slot, 1'b1}] <= pos_ff[1];
      end
   end

   // Replay request: door module command or keyless unlock
   logic fault_ff;
   logic play_block, play_slot, play_req;
   assign play_block = ~ign_s | ~park_s | speed_long | manual_any |
                       stop_s | fault_ff;
   assign play_slot = unlock_ev ? key_slot : pend_slot_ff;
   assign play_req = (commit_play | unlock_ev) &
                     valid_ff[play_slot] & ~play_block;

   // Replay sequencer with staggered motor start
   column_mem_pkg::play_e play_ff;
   logic [CNT_W-1:0] stg_cnt_ff;
   logic tgt_slot_ff;
   logic [1:0] at_tgt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         play_ff <= column_mem_pkg::P_IDLE;
         stg_cnt_ff <= '0;
         tgt_slot_ff <= 1'b0;
      end else if (play_block) begin
         play_ff <= column_mem_pkg::P_IDLE;
      end else if (play_req) begin
         // Newest request retargets and restarts the sequence
         play_ff <= column_mem_pkg::P_TILT;
         stg_cnt_ff <= '0;
         tgt_slot_ff <= play_slot;
      end else begin
         case (play_ff)
            column_mem_pkg::P_IDLE: stg_cnt_ff <= '0;
            column_mem_pkg::P_TILT: begin
               // Telescope waits a full stagger after tilt start
               if (stg_cnt_ff == STG_END) begin
                  play_ff <= column_mem_pkg::P_TELE;
               end else begin
                  stg_cnt_ff <= stg_cnt_ff + 1'b1;
               end
            end
            column_mem_pkg::P_TELE: begin
               if (&at_tgt) play_ff <= column_mem_pkg::P_IDLE;
            end
            default: play_ff <= column_mem_pkg::P_IDLE;
         endcase
      end
   end

   // Per-axis drive, position and sensor supervision
   logic [1:0] fault_set, fault_clr;
   for (genvar a = 0; a < 2; a++) begin : axis
      logic [PW-1:0] tgt;
      logic auto_en, nxt_pos, nxt_neg, drive_d_ff, win_on_ff, win_man_ff;
      logic [CNT_W-1:0] win_cnt_ff;
      logic [2:0] pcnt_ff;
      assign tgt = slot_pos_ff[{tgt_slot_ff, 1'(a)}];
      // Axis counts as done at target or when its travel is blocked
      assign at_tgt[a] = (pos_ff[a] == tgt) | ~lim[a];
      assign auto_en = (a == 0) ? (play_ff != column_mem_pkg::P_IDLE) :
                       (play_ff == column_mem_pkg::P_TELE);
      always_comb begin
         nxt_pos = 1'b0;
         nxt_neg = 1'b0;
         if (manual_any) begin
            // Manual wins and is never blocked by a fault
            nxt_pos = sw_pos[a] & ~sw_neg[a] & lim[a];
            nxt_neg = sw_neg[a] & ~sw_pos[a] & lim[a];
         end else if (auto_en && !play_block && lim[a]) begin
            // Signed compare picks the direction toward the target
            nxt_pos = $signed(tgt) > $signed(pos_ff[a]);
            nxt_neg = $signed(tgt) < $signed(pos_ff[a]);
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mot_pos_ff[a] <= 1'b0;
            mot_neg_ff[a] <= 1'b0;
         end else begin
            mot_pos_ff[a] <= nxt_pos;
            mot_neg_ff[a] <= nxt_neg;
         end
      end
      // Direction of the running motor signs each sensor pulse
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) pos_ff[a] <= '0;
         else if (pulse_rise[a] && mot_pos_ff[a])
            pos_ff[a] <= pos_ff[a] + 1'b1;
         else if (pulse_rise[a] && mot_neg_ff[a])
            pos_ff[a] <= pos_ff[a] - 1'b1;
      end
      // One-second pulse window opened at each motor start
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            drive_d_ff <= 1'b0;
            win_on_ff <= 1'b0;
            win_man_ff <= 1'b0;
            win_cnt_ff <= '0;
            pcnt_ff <= 3'h0;
         end else begin
            drive_d_ff <= mot_pos_ff[a] | mot_neg_ff[a];
            if ((mot_pos_ff[a] | mot_neg_ff[a]) && !drive_d_ff) begin
               win_on_ff <= 1'b1;
               win_man_ff <= manual_any;
               win_cnt_ff <= '0;
               pcnt_ff <= 3'h0;
            end else if (!(mot_pos_ff[a] | mot_neg_ff[a])) begin
               // Motor stopped early: window abandoned, no verdict
               win_on_ff <= 1'b0;
            end else if (win_on_ff) begin
               if (win_cnt_ff == WIN_END) win_on_ff <= 1'b0;
               win_cnt_ff <= win_cnt_ff + 1'b1;
               if (pulse_rise[a] && pcnt_ff != 3'h7)
                  pcnt_ff <= pcnt_ff + 1'b1;
            end
         end
      end
      // Verdict at window end; blocked travel is not a sensor fault
      assign fault_set[a] = win_on_ff & (win_cnt_ff == WIN_END) &
                            lim[a] & (pcnt_ff < column_mem_pkg::PULSE_MIN);
      assign fault_clr[a] = win_on_ff & (win_cnt_ff == WIN_END) &
                            win_man_ff &
                            (pcnt_ff > column_mem_pkg::PULSE_MIN);
   end

   // Fault flag: a new fault wins over a clear in the same cycle
   logic fault_rise;
   assign fault_rise = (|fault_set) & ~fault_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) fault_ff <= 1'b0;
      else if (|fault_set) fault_ff <= 1'b1;
      else if (|fault_clr) fault_ff <= 1'b0;
   end

   // Buzzer: highest priority event reloads the beep count
   logic [3:0] beep_load, beep_left_ff;
   logic [CNT_W-1:0] beep_cnt_ff;
   logic buz_ff;
   always_comb begin
      if (fault_rise) beep_load = column_mem_pkg::BEEPS_FAULT;
      else if (store_en) beep_load = column_mem_pkg::BEEPS_REG;
      else if (play_req) beep_load = column_mem_pkg::BEEPS_PLAY;
      else if (permit_rise)
         beep_load = column_mem_pkg::BEEPS_PERMIT;
      else beep_load = 4'h0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beep_left_ff <= 4'h0;
         beep_cnt_ff <= '0;
         buz_ff <= 1'b0;
      end else if (beep_load != 4'h0) begin
         beep_left_ff <= beep_load;
         beep_cnt_ff <= '0;
         buz_ff <= 1'b1;
      end else if (beep_left_ff != 4'h0) begin
         // Equal on and off phases; count drops as each tone ends
         if (beep_cnt_ff == BEEP_END) begin
            beep_cnt_ff <= '0;
            if (buz_ff) beep_left_ff <= beep_left_ff - 1'b1;
            buz_ff <= ~buz_ff;
         end else begin
            beep_cnt_ff <= beep_cnt_ff + 1'b1;
         end
      end else begin
         buz_ff <= 1'b0;
      end
   end

   // Read data registered in the setup phase, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) begin
         case (paddr)
            column_mem_pkg::STAT_OFS:
               prdata <= {25'h000_0000, pend_ff, buz_ff, fault_ff,
                          play_ff != column_mem_pkg::P_IDLE, valid_ff,
                          permit_ff};
            column_mem_pkg::POS_OFS: prdata <= {pos_ff[1], pos_ff[0]};
            column_mem_pkg::SLOT0_OFS:
               prdata <= {slot_pos_ff[1], slot_pos_ff[0]};
            column_mem_pkg::SLOT1_OFS:
               prdata <= {slot_pos_ff[3], slot_pos_ff[2]};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign mot_pos = mot_pos_ff;
   assign mot_neg = mot_neg_ff;
   assign buzzer = buz_ff;

   // Checks on the guarded behaviour
   man_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      sw_pos[0] && !sw_neg[0] && lim[0] |=> mot_pos_ff[0])
      else $error("manual tilt switch did not drive motor");
   limit_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !lim[1] |=> !mot_pos_ff[1] && !mot_neg_ff[1])
      else $error("telescope driven with limit off");
   permit_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!ign_s || manual_any) |=> !permit_ff)
      else $error("permit kept with ignition off or manual");
   store_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lock_ev && !store_ok) |=> $stable(valid_ff))
      else $error("slot stored outside park or above speed");
   empty_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
      (play_ff == column_mem_pkg::P_IDLE && commit_play && !unlock_ev &&
       !valid_ff[pend_slot_ff]) |=> play_ff == column_mem_pkg::P_IDLE)
      else $error("replay started for empty slot");
   play_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
      play_block |=> play_ff == column_mem_pkg::P_IDLE ##1
      !mot_pos_ff[1] || manual_any || $past(manual_any))
      else $error("replay not stopped by inhibit");
   stagger_a: assert property (@(posedge pclk) disable iff (!presetn)
      (play_ff == column_mem_pkg::P_TILT && stg_cnt_ff != STG_END)
      |=> play_ff != column_mem_pkg::P_TELE)
      else $error("telescope started before stagger elapsed");
   fault_beep_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(fault_ff) |-> beep_left_ff == 4'ha && buz_ff)
      else $error("fault did not load ten beeps");
   fault_manual_a: assert property (@(posedge pclk) disable iff (!presetn)
      fault_ff && sw_neg[0] && !sw_pos[0] && lim[0] |=> mot_neg_ff[0])
      else $error("manual drive lost during fault");
   reg_cv: cover property (@(posedge pclk) disable iff (!presetn)
      commit_reg && store_ok);
   tele_cv: cover property (@(posedge pclk) disable iff (!presetn)
      play_ff == column_mem_pkg::P_TELE && mot_pos_ff[1]);
   fault_cv: cover property (@(posedge pclk) disable iff (!presetn)
      $fell(fault_ff));
endmodule
`default_nettype wire

// File: tb/door_module_model.sv
// Purpose: Door module stand-in issuing register transfers to the column
// Assumes: Zero or more wait states; answer sampled at a rising edge
// Notes: Callers enter the task just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module door_module_model (
   // Clock
   input wire logic pclk,
   // Bus request side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // Bus answer side
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero so nothing is taken during reset
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // Store and replay requests only ever come through here
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Request held until ready is seen; the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps two requests from colliding in a time step
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the column memory controller
// Assumes: Shortened timing parameters, ignition on and park held except in the park and ignition tests
// Notes: Manual cases run from a table, the rest by hand
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, buzzer;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic e, speed_high, stop_sw, ign_on, park_on;
   logic [1:0] man_pos_sw, man_neg_sw, limit_ok, sens_pulse, mot_pos, mot_neg;
   int num_errors = 0;
   int checks_done = 0;
   int cyc_count = 0;
   // Rows: {pos sw, neg sw, limit, expected pos drive, expected neg drive}
   logic [9:0] rows [4] = '{10'b01_00_11_01_00, 10'b00_10_11_00_10,
      10'b01_00_10_00_00, 10'b01_01_11_00_00};
   column_mem_ctrl #(.GAP_CYC(20), .STAGGER_CYC(30), .WIN_CYC(200),
      .SPEED_CYC(40), .BEEP_CYC(10)) column_mem_ctrl_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ign_on(ign_on), .park_on(park_on),
      .speed_high(speed_high), .stop_sw(stop_sw), .man_pos_sw(man_pos_sw),
      .man_neg_sw(man_neg_sw), .limit_ok(limit_ok), .sens_pulse(sens_pulse),
      .mot_pos(mot_pos), .mot_neg(mot_neg), .buzzer(buzzer));
   door_module_model door_module_model_inst (.pclk(pclk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Clock at 10 MHz
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Hang guard, well beyond the planned run
   always @(posedge pclk) begin
      cyc_count++;
      if (cyc_count == 20000) begin
         num_errors++;
         results();
      end
   end
   task automatic results();
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      door_module_model_inst.xfer(1'b1, a, d, q, e);
   endtask
   // Status read compared under a mask, since buzzer bits wander
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] exp);
      door_module_model_inst.xfer(1'b0, a, 32'h0, q, e);
      check(q & m, exp);
   endtask
   // Sensor pulses long enough for the synchroniser to see
   task automatic pulses(input int n);
      repeat (n) begin
         sens_pulse <= 2'b01;
         wait_cyc(4);
         sens_pulse <= 2'b00;
         wait_cyc(4);
      end
   endtask
   initial begin
      {presetn, speed_high, stop_sw} = 3'b000;
      {ign_on, park_on} = 2'b11;
      {man_pos_sw, man_neg_sw, sens_pulse} = 6'h0;
      limit_ok = 2'b11;
      wait_cyc(8);
      presetn <= 1'b1;
      wait_cyc(2);
      rdchk(column_mem_pkg::STAT_OFS, 32'h1f, 32'h0);
      foreach (rows[i]) begin
         {man_pos_sw, man_neg_sw, limit_ok} <= rows[i][9:4];
         wait_cyc(6);
         check({mot_pos, mot_neg}, rows[i][3:0]);
         {man_pos_sw, man_neg_sw, limit_ok} <= 6'b000011;
         wait_cyc(5);
      end
      door_module_model_inst.xfer(1'b0, 8'h40, 32'h0, q, e);
      check(e, 1'b1);
      wr(column_mem_pkg::CMD_OFS, 32'h1);
      check(buzzer, 1'b1);
      wr(column_mem_pkg::CMD_OFS, 32'h6);
      wait_cyc(25);
      rdchk(column_mem_pkg::STAT_OFS, 32'h6, 32'h0);
      wr(column_mem_pkg::CMD_OFS, 32'h1);
      wr(column_mem_pkg::CMD_OFS, 32'h2);
      wait_cyc(25);
      rdchk(column_mem_pkg::STAT_OFS, 32'h6, 32'h2);
      speed_high <= 1'b1;
      wait_cyc(5);
      wr(column_mem_pkg::CMD_OFS, 32'h1);
      wr(column_mem_pkg::CMD_OFS, 32'h4);
      wait_cyc(25);
      rdchk(column_mem_pkg::STAT_OFS, 32'h4, 32'h0);
      speed_high <= 1'b0;
      wr(column_mem_pkg::CMD_OFS, 32'h10);
      wait_cyc(25);
      rdchk(column_mem_pkg::STAT_OFS, 32'h8, 32'h0);
      // Move tilt away from the stored spot by three counts
      man_pos_sw <= 2'b01;
      wait_cyc(6);
      pulses(3);
      man_pos_sw <= 2'b00;
      wait_cyc(5);
      rdchk(column_mem_pkg::POS_OFS, 32'hffff, 32'h3);
      wr(column_mem_pkg::CMD_OFS, 32'h8);
      wait_cyc(22);
      check({mot_pos, mot_neg}, 4'b0001);
      rdchk(column_mem_pkg::STAT_OFS, 32'h8, 32'h8);
      stop_sw <= 1'b1;
      wait_cyc(5);
      check({mot_pos, mot_neg}, 4'b0000);
      stop_sw <= 1'b0;
      // Manual run with a dead sensor outlasts the check window
      man_pos_sw <= 2'b01;
      wait_cyc(215);
      man_pos_sw <= 2'b00;
      wait_cyc(3);
      rdchk(column_mem_pkg::STAT_OFS, 32'h10, 32'h10);
      // Fault blocks replay, then a healthy manual run clears it
      wr(column_mem_pkg::CMD_OFS, 32'h8);
      wait_cyc(25);
      rdchk(column_mem_pkg::STAT_OFS, 32'h8, 32'h0);
      man_pos_sw <= 2'b01;
      wait_cyc(6);
      pulses(6);
      wait_cyc(160);
      man_pos_sw <= 2'b00;
      wait_cyc(3);
      rdchk(column_mem_pkg::STAT_OFS, 32'h10, 32'h0);
      // Keyless store refused outside park, then overwrites slot 0
      park_on <= 1'b0;
      wait_cyc(4);
      wr(column_mem_pkg::CMD_OFS, 32'h20);
      rdchk(column_mem_pkg::SLOT0_OFS, 32'hffff_ffff, 32'h0);
      park_on <= 1'b1;
      wait_cyc(4);
      wr(column_mem_pkg::CMD_OFS, 32'h20);
      rdchk(column_mem_pkg::SLOT0_OFS, 32'hffff_ffff, 32'h9);
      // Keyless store into slot 1, then unlock replays it
      wr(column_mem_pkg::CMD_OFS, 32'ha0);
      wr(column_mem_pkg::CMD_OFS, 32'h1);
      wr(column_mem_pkg::CMD_OFS, 32'hc0);
      rdchk(column_mem_pkg::STAT_OFS, 32'hd, 32'hd);
      // Ignition off drops permit and aborts replay
      ign_on <= 1'b0;
      wait_cyc(4);
      rdchk(column_mem_pkg::STAT_OFS, 32'h9, 32'h0);
      ign_on <= 1'b1;
      results();
   end
endmodule
`default_nettype wire
